//--- logic/fcdm_defs.svh
// constants for the five channel duty modulator: offsets, fields, reset values
// assumes an apb slave with byte addresses four times the register index
// Operation
// - five modulated channels 0..4, each can take over one port pin
// - one shared 8-bit prescaler clocks the common 8-bit counter
// - output is 0 when duty <= counter, 1 when duty > counter
// - first control: bits 7,6,3,2 pin select ch3,2,1,0; bits 5,4,1,0 enable
// - second control: bit 2 pin select ch4, bit 0 enable ch4, rest reserved
// - enable 1 runs the channel, enable 0 stops it
// - pin carries modulated signal only while pin select is 1
// - prescaler divides by period register value plus one, for all channels
// - repetition rate is clock over (period plus one) times 255
// - high fraction equals duty over 255
// - duty 00h holds low, duty ffh holds high
// - a new duty value acts on the output at once
// - each channel has its own readable writable 8-bit duty register
// - all registers reset to zero: channels stopped, pins general purpose
`ifndef FCDM_DEFS_SVH
`define FCDM_DEFS_SVH
// register indices; byte address is four times these
`define FCDM_IDX_CH4_CTRL 8'hce
`define FCDM_IDX_CH4_DUTY 8'hcf
`define FCDM_IDX_PERIOD 8'hd9
`define FCDM_IDX_CH0_DUTY 8'hda
`define FCDM_IDX_CH1_DUTY 8'hdb
`define FCDM_IDX_CTRL0 8'hdc
`define FCDM_IDX_CH2_DUTY 8'hdd
`define FCDM_IDX_CH3_DUTY 8'hde
`define FCDM_REG_RESET 8'h00
`define FCDM_CTRL1_MASK 8'h05
`define FCDM_CNT_LAST 8'hfe
`define FCDM_CNT_ZERO 8'h00
`define FCDM_ADDR_LSB 2
`define FCDM_STEP 8'h01
`define FCDM_FULL_MASK 8'hff
`define FCDM_BYTE_MSB 7
`define FCDM_UPPER_ZERO 24'h000000
// field positions
`define FCDM_B_EN0 0
`define FCDM_B_EN1 1
`define FCDM_B_SEL0 2
`define FCDM_B_SEL1 3
`define FCDM_B_EN2 4
`define FCDM_B_EN3 5
`define FCDM_B_SEL2 6
`define FCDM_B_SEL3 7
`define FCDM_B_EN4 0
`define FCDM_B_SEL4 2
`endif

//--- logic/fcdm_pkg.sv
// types shared by the duty modulator
// assumes fcdm_defs.svh holds the numeric constants
package fcdm_pkg;
  typedef logic [7:0] fcdm_byte_t;
  typedef logic [4:0] fcdm_chan_t;
endpackage

//--- logic/fcdm_top.sv
// five channel duty modulator with apb register access
// assumes a single 250 mhz clock and apb master at the pins
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "fcdm_defs.svh"
module fcdm_top (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output fcdm_pkg::fcdm_chan_t CHAN_OUT,
  output fcdm_pkg::fcdm_chan_t PIN_SELECT,
  output fcdm_pkg::fcdm_chan_t PIN_OUT
);
  import fcdm_pkg::*;

  // control and period registers
  fcdm_byte_t ctrl0_reg;
  fcdm_byte_t ctrl1_reg;
  fcdm_byte_t period_reg;

  // one duty register per channel
  fcdm_byte_t duty0_reg;
  fcdm_byte_t duty1_reg;
  fcdm_byte_t duty2_reg;
  fcdm_byte_t duty3_reg;
  fcdm_byte_t duty4_reg;

  // shared prescaler and counter
  fcdm_byte_t pre_reg;
  fcdm_byte_t cnt_reg;

  // registered outputs
  fcdm_chan_t out_reg;
  fcdm_chan_t sel_reg;
  fcdm_chan_t pin_reg;
  logic [31:0] rdata_reg;
  logic ready_reg;
  logic err_reg;

  // register index from byte address
  function automatic logic [7:0] idx_of(input logic [31:0] a);
    idx_of = a[`FCDM_ADDR_LSB+7:`FCDM_ADDR_LSB];
  endfunction

  // whole-word match only: upper bits and byte lanes must be zero
  function automatic logic addr_hit(input logic [31:0] a, input logic [7:0] index);
    logic upper_zero;
    logic lane_zero;
    upper_zero = (a[31:`FCDM_ADDR_LSB+8] == '0);
    lane_zero = (a[`FCDM_ADDR_LSB-1:0] == '0);
    addr_hit = upper_zero && lane_zero && (idx_of(a) == index);
  endfunction

  // channel is high while its duty is above the count
  function automatic logic duty_above(input fcdm_byte_t duty, input fcdm_byte_t count);
    duty_above = (duty > count);
  endfunction

  // plain increment shared by prescaler and counter
  function automatic fcdm_byte_t step_up(input fcdm_byte_t value);
    step_up = value + `FCDM_STEP;
  endfunction

  // new byte for a register on write, old value otherwise
  function automatic fcdm_byte_t merge_byte(input logic we, input fcdm_byte_t bus,
    input fcdm_byte_t mask, input fcdm_byte_t old);
    merge_byte = we ? (bus & mask) : old;
  endfunction

  // bus phases
  wire logic setup = PSEL && !PENABLE;
  wire logic access_phase = PSEL && PENABLE;
  // write commits only at the edge where the master samples ready
  wire logic commit = access_phase && ready_reg;
  wire logic wr = commit && PWRITE;
  wire fcdm_byte_t wb = PWDATA[`FCDM_BYTE_MSB:0];

  // address decode
  wire logic hit_c1 = addr_hit(PADDR, `FCDM_IDX_CH4_CTRL);
  wire logic hit_d4 = addr_hit(PADDR, `FCDM_IDX_CH4_DUTY);
  wire logic hit_p = addr_hit(PADDR, `FCDM_IDX_PERIOD);
  wire logic hit_d0 = addr_hit(PADDR, `FCDM_IDX_CH0_DUTY);
  wire logic hit_d1 = addr_hit(PADDR, `FCDM_IDX_CH1_DUTY);
  wire logic hit_c0 = addr_hit(PADDR, `FCDM_IDX_CTRL0);
  wire logic hit_d2 = addr_hit(PADDR, `FCDM_IDX_CH2_DUTY);
  wire logic hit_d3 = addr_hit(PADDR, `FCDM_IDX_CH3_DUTY);
  wire logic mapped = hit_c1 | hit_d4 | hit_p | hit_d0 | hit_d1 | hit_c0 | hit_d2 | hit_d3;

  // per-register write strobes; unmapped writes are dropped
  wire logic wr_c0 = wr && hit_c0;
  wire logic wr_c1 = wr && hit_c1;
  wire logic wr_p = wr && hit_p;
  wire logic wr_d0 = wr && hit_d0;
  wire logic wr_d1 = wr && hit_d1;
  wire logic wr_d2 = wr && hit_d2;
  wire logic wr_d3 = wr && hit_d3;
  wire logic wr_d4 = wr && hit_d4;

  // next values; reserved bits of channel4_control stay zero
  wire fcdm_byte_t ctrl0_next = merge_byte(wr_c0, wb, `FCDM_FULL_MASK, ctrl0_reg);
  wire fcdm_byte_t ctrl1_next = merge_byte(wr_c1, wb, `FCDM_CTRL1_MASK, ctrl1_reg);
  wire fcdm_byte_t period_next = merge_byte(wr_p, wb, `FCDM_FULL_MASK, period_reg);
  wire fcdm_byte_t duty0_next = merge_byte(wr_d0, wb, `FCDM_FULL_MASK, duty0_reg);
  wire fcdm_byte_t duty1_next = merge_byte(wr_d1, wb, `FCDM_FULL_MASK, duty1_reg);
  wire fcdm_byte_t duty2_next = merge_byte(wr_d2, wb, `FCDM_FULL_MASK, duty2_reg);
  wire fcdm_byte_t duty3_next = merge_byte(wr_d3, wb, `FCDM_FULL_MASK, duty3_reg);
  wire fcdm_byte_t duty4_next = merge_byte(wr_d4, wb, `FCDM_FULL_MASK, duty4_reg);

  // read mux, taken in the setup cycle
  wire fcdm_byte_t rsel =
    hit_c1 ? ctrl1_reg :
    hit_d4 ? duty4_reg :
    hit_p ? period_reg :
    hit_d0 ? duty0_reg :
    hit_d1 ? duty1_reg :
    hit_c0 ? ctrl0_reg :
    hit_d2 ? duty2_reg :
    hit_d3 ? duty3_reg :
    `FCDM_REG_RESET;

  // enables and pin selects per channel
  wire logic chan0_run_enable = ctrl0_reg[`FCDM_B_EN0];
  wire logic chan1_run_enable = ctrl0_reg[`FCDM_B_EN1];
  wire logic chan2_run_enable = ctrl0_reg[`FCDM_B_EN2];
  wire logic chan3_run_enable = ctrl0_reg[`FCDM_B_EN3];
  wire logic chan4_run_enable = ctrl1_reg[`FCDM_B_EN4];
  wire logic chan0_pin_select = ctrl0_reg[`FCDM_B_SEL0];
  wire logic chan1_pin_select = ctrl0_reg[`FCDM_B_SEL1];
  wire logic chan2_pin_select = ctrl0_reg[`FCDM_B_SEL2];
  wire logic chan3_pin_select = ctrl0_reg[`FCDM_B_SEL3];
  wire logic chan4_pin_select = ctrl1_reg[`FCDM_B_SEL4];
  wire fcdm_chan_t run_en = {chan4_run_enable, chan3_run_enable, chan2_run_enable,
    chan1_run_enable, chan0_run_enable};
  wire fcdm_chan_t pin_sel = {chan4_pin_select, chan3_pin_select, chan2_pin_select,
    chan1_pin_select, chan0_pin_select};

  // counter holds while every channel is stopped
  wire logic any_en = |run_en;
  // prescaler divides by period+1
  wire logic tick = any_en && (pre_reg == period_reg);
  wire fcdm_byte_t pre_next = (!any_en || tick) ? `FCDM_REG_RESET : step_up(pre_reg);
  // 255 counts per period, so rate is clk/((period+1)*255)
  wire logic cnt_wrap = (cnt_reg == `FCDM_CNT_LAST);
  wire fcdm_byte_t cnt_next = !tick ? cnt_reg : cnt_wrap ? `FCDM_CNT_ZERO : step_up(cnt_reg);

  // compare against live duty, so a new value acts at once
  wire logic cmp0 = chan0_run_enable && duty_above(duty0_reg, cnt_reg);
  wire logic cmp1 = chan1_run_enable && duty_above(duty1_reg, cnt_reg);
  wire logic cmp2 = chan2_run_enable && duty_above(duty2_reg, cnt_reg);
  wire logic cmp3 = chan3_run_enable && duty_above(duty3_reg, cnt_reg);
  wire logic cmp4 = chan4_run_enable && duty_above(duty4_reg, cnt_reg);
  wire fcdm_chan_t out_next = {cmp4, cmp3, cmp2, cmp1, cmp0};
  // pin carries the signal only while selected; low otherwise for the gpio mux
  wire fcdm_chan_t sel_next = pin_sel;
  wire fcdm_chan_t pin_next = out_next & pin_sel;

  // bus answer: no wait state, ready in the first access cycle
  wire logic ready_next = setup;
  wire logic err_next = setup && !mapped;
  wire logic [31:0] rdata_next = setup ? {`FCDM_UPPER_ZERO, rsel} : rdata_reg;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl0_reg <= `FCDM_REG_RESET;
    end else begin
      ctrl0_reg <= ctrl0_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl1_reg <= `FCDM_REG_RESET;
    end else begin
      ctrl1_reg <= ctrl1_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      period_reg <= `FCDM_REG_RESET;
    end else begin
      period_reg <= period_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      duty0_reg <= `FCDM_REG_RESET;
    end else begin
      duty0_reg <= duty0_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      duty1_reg <= `FCDM_REG_RESET;
    end else begin
      duty1_reg <= duty1_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      duty2_reg <= `FCDM_REG_RESET;
    end else begin
      duty2_reg <= duty2_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      duty3_reg <= `FCDM_REG_RESET;
    end else begin
      duty3_reg <= duty3_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      duty4_reg <= `FCDM_REG_RESET;
    end else begin
      duty4_reg <= duty4_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pre_reg <= `FCDM_REG_RESET;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // counter keeps its value while stopped, so a restart resumes mid-period
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_reg <= `FCDM_CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel_reg <= '0;
    end else begin
      sel_reg <= sel_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_reg <= '0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
    end
  end

  assign PRDATA = rdata_reg;
  assign PREADY = ready_reg;
  assign PSLVERR = err_reg;
  assign CHAN_OUT = out_reg;
  assign PIN_SELECT = sel_reg;
  assign PIN_OUT = pin_reg;
endmodule

//--- dv/fcdm_pin_load.sv
// external load on the five shared port pins
// assumes gpio levels come from the bench
`timescale 1ns/10ps
module fcdm_pin_load (
  input wire logic [4:0] pin_out,
  input wire logic [4:0] sel,
  input wire logic [4:0] gpio,
  output logic [4:0] pins
);
  // unselected pins keep their gpio level even when the channel runs
  assign pins = (pin_out & sel) | (gpio & ~sel);
endmodule

//--- dv/fcdm_sva.sv
// port checker for the duty modulator
// assumes apb answers one cycle after setup
`timescale 1ns/10ps
module fcdm_sva (
  input wire logic CLK, RESET_N, PSEL, PENABLE, PWRITE,
  input wire logic [31:0] PADDR, PWDATA, PRDATA,
  input wire logic PREADY, PSLVERR,
  input wire fcdm_pkg::fcdm_chan_t CHAN_OUT, PIN_SELECT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence setup_s; PSEL && !PENABLE; endsequence
  sequence ctrl0_wr_s; setup_s ##0 PWRITE && PADDR == 32'h370; endsequence
  a_ready_after_setup: assert property (setup_s |=> PREADY) else $error("no ready");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("long ready");
  a_err_with_ready: assert property (PSLVERR |-> PREADY) else $error("lone error");
  a_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper");
  a_err_reads_zero: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("error read");
  a_ctrl1_reserved: assert property (PREADY && !PWRITE && PADDR == 32'h338
    |-> (PRDATA & 32'hfa) == 32'h0) else $error("reserved bits");
  a_stop_when_off: assert property (ctrl0_wr_s ##0 (PWDATA & 32'h33) == 0
    |=> ##2 CHAN_OUT[3:0] == 4'h0) else $error("channel runs");
  a_sel_follows: assert property (ctrl0_wr_s |=> ##2 PIN_SELECT[3:0] ==
    {$past(PWDATA[7:6], 3), $past(PWDATA[3:2], 3)}) else $error("pin select");
endmodule
bind fcdm_top fcdm_sva fcdm_sva_inst (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .CHAN_OUT(CHAN_OUT), .PIN_SELECT(PIN_SELECT));

//--- dv/tb.sv
// bench for the duty modulator over apb
// assumes one 250 mhz clock
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
module tb;
  import fcdm_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  fcdm_chan_t chan, sel, pout, pins;
  int miscompares = 0, num_checks = 0, cyc = 0, ch[5], pn[5];
  int ec[5] = '{0, 64, 128, 192, 255}, ep[5] = '{0, 255, 128, 255, 255};
  logic [31:0] pa[8] = '{'h338, 'h33c, 'h364, 'h368, 'h36c, 'h370, 'h374, 'h378};
  logic [31:0] pd[8] = '{'h01, 'hff, 'h00, 'h00, 'h40, 'h77, 'h80, 'hc0};
  fcdm_top fcdm_top_inst (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CHAN_OUT(chan), .PIN_SELECT(sel), .PIN_OUT(pout));
  fcdm_pin_load fcdm_pin_load_inst (.pin_out(pout), .sel(sel), .gpio(5'h1f), .pins(pins));
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (++cyc == 6000) begin
    miscompares++;
    summarize();
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // request held until ready is seen at a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic count(input int n);
    ch = '{default: 0};
    pn = '{default: 0};
    repeat (n) begin
      @(posedge clk);
      foreach (ch[i]) begin
        ch[i] += chan[i];
        pn[i] += pins[i];
      end
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    `CHK("outputs after reset", 15'h0, {chan, sel, pout})
    foreach (pa[i]) begin
      xfer(0, pa[i], 0);
      `CHK("reset value", 32'h0, rd)
      xfer(1, pa[i], pd[i] | (i == 0 ? 32'hfa : 0));
    end
    foreach (pa[i]) begin
      xfer(0, pa[i], 0);
      `CHK("read back", pd[i], rd)
    end
    xfer(0, 32'h0, 0);
    `CHK("unmapped", 33'h100000000, {er, rd})
    $display("registers done");
    repeat (8) @(posedge clk);
    count(255);
    foreach (ch[i]) `CHK("high count", ec[i], ch[i])
    foreach (pn[i]) `CHK("pin count", ep[i], pn[i])
    xfer(1, 32'h364, 1);
    repeat (8) @(posedge clk);
    count(510);
    foreach (ch[i]) `CHK("slow count", 2 * ec[i], ch[i])
    $display("modulation done");
    for (int v = 0; v < 2; v++) begin
      xfer(1, 32'h36c, v * 255);
      repeat (2) @(posedge clk);
      `CHK("fresh duty", v[0], chan[1])
    end
    xfer(1, 32'h370, 32'hcc);
    xfer(1, 32'h338, 32'h04);
    count(20);
    `CHK("stopped", 10'h3e0, {sel, chan | pins})
    $display("stop done");
    summarize();
  end
endmodule
